// >>> lwt_watchdog.sv
// loop watchdog and interval timer top level
module lwt_watchdog import lwt_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    input wire logic cs_wr,
    input wire logic [7:0] cs_wdata,
    input wire logic cpu_stop,
    input wire logic cpu_on_subclock,
    input wire logic interval_irq_mask,
    input wire logic irq_flag_clr,
    output logic [7:0] wd_mode_register,
    output logic [7:0] wd_clock_select_register,
    output logic wd_irq_request_flag,
    output logic interval_overflow_irq,
    output logic nmi_req,
    output logic wdt_reset_req
);
    lwt_ctrl_s ctrl;
    lwt_ctrl_s next_ctrl;
    logic [2:0] sel;
    logic [2:0] next_sel;
    lwt_mode_e mode;
    logic restart;
    logic count_en;
    logic tick;
    logic ovf;
    logic [LWT_CNT_W-1:0] cnt;
    logic wden_rise;
    logic next_flag;
    logic next_irq;
    logic next_nmi;
    logic next_rst;

    // control registers
    always_comb begin
        next_ctrl.run = ctrl.run | (mode_wr & mode_wdata[LWT_RUN_POS]);
        next_ctrl.wden = ctrl.wden | (mode_wr & mode_wdata[LWT_WDEN_POS]);
        next_ctrl.act = ctrl.act | (mode_wr & mode_wdata[LWT_ACT_POS]);
        next_sel = cs_wr ? cs_wdata[LWT_SEL_HI:LWT_SEL_LO] : sel;
        restart = mode_wr & mode_wdata[LWT_RUN_POS];
        wden_rise = next_ctrl.wden & ~ctrl.wden;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
            sel <= LWT_SEL_RST;
        end else begin
            ctrl <= next_ctrl;
            sel <= next_sel;
        end
    end

    // mode decode; interval needs wden low so it is unreachable once set
    always_comb begin
        unique case ({ctrl.wden, ctrl.act})
            2'b00: mode = LWT_STOPPED;
            2'b01: mode = LWT_INTERVAL;
            2'b10: mode = LWT_WD_NMI;
            2'b11: mode = LWT_WD_RESET;
        endcase
        // halt does not gate counting
        count_en = ctrl.run && (mode != LWT_STOPPED) && !cpu_stop
            && !cpu_on_subclock;
    end

    lwt_prescaler u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .en(count_en),
        .sel(sel),
        .tick(tick)
    );

    lwt_counter u_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .clr(restart),
        .tick(tick),
        .cnt(cnt),
        .ovf(ovf)
    );

    // overflow actions and request flag
    always_comb begin
        next_flag = wd_irq_request_flag;
        if (irq_flag_clr) begin
            next_flag = 1'b0;
        end
        if (ovf && (mode != LWT_STOPPED)) begin
            next_flag = 1'b1; // set wins over clear
        end
        next_irq = next_flag && !interval_irq_mask
            && (mode == LWT_INTERVAL);
        next_nmi = (ovf && (mode == LWT_WD_NMI))
            || (wden_rise && wd_irq_request_flag);
        next_rst = ovf && (mode == LWT_WD_RESET);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_irq_request_flag <= 1'b0;
            interval_overflow_irq <= 1'b0;
            nmi_req <= 1'b0;
            wdt_reset_req <= 1'b0;
            wd_mode_register <= LWT_MODE_RST;
            wd_clock_select_register <= LWT_MODE_RST;
        end else begin
            wd_irq_request_flag <= next_flag;
            interval_overflow_irq <= next_irq;
            nmi_req <= next_nmi;
            wdt_reset_req <= next_rst;
            wd_mode_register <= {next_ctrl.run, 2'b00, next_ctrl.wden, next_ctrl.act, 3'b000};
            wd_clock_select_register <= {5'b00000, next_sel};
        end
    end

    property p_run_sticky;
        @(posedge clk) disable iff (!rst_n) ctrl.run |=> ctrl.run;
    endproperty
    a_run_sticky: assert property (p_run_sticky) else $error("run bit cleared");

    property p_mode_sticky;
        @(posedge clk) disable iff (!rst_n)
            (ctrl.wden || ctrl.act) |=> ($past(ctrl.wden) <= ctrl.wden)
            && ($past(ctrl.act) <= ctrl.act);
    endproperty
    a_mode_sticky: assert property (p_mode_sticky) else $error("mode bit cleared");

    property p_no_interval_after_wd;
        @(posedge clk) disable iff (!rst_n) ctrl.wden |-> ##[0:8] mode != LWT_INTERVAL;
    endproperty
    a_no_interval_after_wd: assert property (p_no_interval_after_wd)
        else $error("interval after watchdog");

    property p_restart;
        @(posedge clk) disable iff (!rst_n) restart |=> cnt == LWT_CNT_RST && !ovf;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear");

    property p_stop_freeze;
        @(posedge clk) disable iff (!rst_n)
            (cpu_stop || cpu_on_subclock) && !restart |=> $stable(cnt);
    endproperty
    a_stop_freeze: assert property (p_stop_freeze) else $error("counted while frozen");

    property p_nmi;
        @(posedge clk) disable iff (!rst_n)
            ovf && mode == LWT_WD_NMI |=> nmi_req && !wdt_reset_req ##1 wd_irq_request_flag;
    endproperty
    a_nmi: assert property (p_nmi) else $error("missing nmi");

    property p_reset;
        @(posedge clk) disable iff (!rst_n) ovf && mode == LWT_WD_RESET |=> wdt_reset_req;
    endproperty
    a_reset: assert property (p_reset) else $error("missing reset request");

    property p_interval_irq;
        @(posedge clk) disable iff (!rst_n)
            ovf && mode == LWT_INTERVAL && !interval_irq_mask |=> interval_overflow_irq;
    endproperty
    a_interval_irq: assert property (p_interval_irq) else $error("missing interval irq");

    property p_pending_nmi;
        @(posedge clk) disable iff (!rst_n)
            wden_rise && wd_irq_request_flag |=> nmi_req;
    endproperty
    a_pending_nmi: assert property (p_pending_nmi) else $error("pending flag no nmi");

    property p_no_ovf_stopped;
        @(posedge clk) disable iff (!rst_n) !ctrl.run |-> !tick;
    endproperty
    a_no_ovf_stopped: assert property (p_no_ovf_stopped) else $error("tick while stopped");

    property p_sel_readback;
        @(posedge clk) disable iff (!rst_n)
            cs_wr |=> wd_clock_select_register[2:0] == $past(cs_wdata[2:0]);
    endproperty
    a_sel_readback: assert property (p_sel_readback)
        else $error("select readback wrong");

    property p_mode_readback;
        @(posedge clk) disable iff (!rst_n)
            1'b1 |-> wd_mode_register == {ctrl.run, 2'b00, ctrl.wden, ctrl.act, 3'b000};
    endproperty
    a_mode_readback: assert property (p_mode_readback)
        else $error("mode readback wrong");

    property p_restart_sets_run;
        @(posedge clk) disable iff (!rst_n)
            restart |=> ctrl.run;
    endproperty
    a_restart_sets_run: assert property (p_restart_sets_run)
        else $error("run not set");

    property p_wden_set;
        @(posedge clk) disable iff (!rst_n)
            mode_wr && mode_wdata[LWT_WDEN_POS] |=> ctrl.wden;
    endproperty
    a_wden_set: assert property (p_wden_set)
        else $error("watchdog enable not set");

    property p_act_set;
        @(posedge clk) disable iff (!rst_n)
            mode_wr && mode_wdata[LWT_ACT_POS] |=> ctrl.act;
    endproperty
    a_act_set: assert property (p_act_set)
        else $error("action bit not set");

    property p_no_tick_stop;
        @(posedge clk) disable iff (!rst_n)
            cpu_stop |-> !tick;
    endproperty
    a_no_tick_stop: assert property (p_no_tick_stop)
        else $error("tick in stop");

    property p_no_tick_sub;
        @(posedge clk) disable iff (!rst_n)
            cpu_on_subclock |-> !tick;
    endproperty
    a_no_tick_sub: assert property (p_no_tick_sub)
        else $error("tick on subclock");

    property p_tick_counts;
        @(posedge clk) disable iff (!rst_n)
            tick && !restart |=> cnt == 7'($past(cnt) + 7'h01);
    endproperty
    a_tick_counts: assert property (p_tick_counts)
        else $error("tick not counted");

    property p_ovf_pulse;
        @(posedge clk) disable iff (!rst_n)
            ovf |=> !ovf;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse)
        else $error("overflow too long");

    property p_reset_pulse;
        @(posedge clk) disable iff (!rst_n)
            wdt_reset_req |=> !wdt_reset_req;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("reset request too long");

    property p_nmi_only_wd;
        @(posedge clk) disable iff (!rst_n)
            nmi_req |-> ctrl.wden;
    endproperty
    a_nmi_only_wd: assert property (p_nmi_only_wd)
        else $error("nmi outside watchdog");

    property p_reset_only_mode2;
        @(posedge clk) disable iff (!rst_n)
            wdt_reset_req |-> ctrl.wden && ctrl.act;
    endproperty
    a_reset_only_mode2: assert property (p_reset_only_mode2)
        else $error("reset request wrong mode");

    property p_irq_only_interval;
        @(posedge clk) disable iff (!rst_n)
            interval_overflow_irq |-> $past(mode == LWT_INTERVAL);
    endproperty
    a_irq_only_interval: assert property (p_irq_only_interval)
        else $error("irq outside interval");

    property p_irq_masked;
        @(posedge clk) disable iff (!rst_n)
            interval_irq_mask |=> !interval_overflow_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("masked irq raised");

    property p_irq_needs_flag;
        @(posedge clk) disable iff (!rst_n)
            interval_overflow_irq |-> wd_irq_request_flag;
    endproperty
    a_irq_needs_flag: assert property (p_irq_needs_flag)
        else $error("irq without flag");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_n)
            ovf && mode != LWT_STOPPED |=> wd_irq_request_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set");

    property p_flag_clr;
        @(posedge clk) disable iff (!rst_n)
            irq_flag_clr && !ovf |=> !wd_irq_request_flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("flag not cleared");

    property p_stopped_idle;
        @(posedge clk) disable iff (!rst_n)
            mode == LWT_STOPPED |-> !tick;
    endproperty
    a_stopped_idle: assert property (p_stopped_idle)
        else $error("tick in stopped mode");
endmodule : lwt_watchdog

// >>> lwt_pkg.sv
// constants and types for the loop watchdog / interval timer
package lwt_pkg;
    localparam int LWT_CLK_HZ = 20_000_000;
    localparam int LWT_REG_W = 8;
    localparam int LWT_PRE_W = 10;
    localparam int LWT_CNT_W = 7;
    localparam int LWT_RUN_POS = 7;
    localparam int LWT_WDEN_POS = 4;
    localparam int LWT_ACT_POS = 3;
    localparam int LWT_SEL_LO = 0;
    localparam int LWT_SEL_HI = 2;
    localparam logic [7:0] LWT_MODE_RST = 8'h00;
    localparam logic [2:0] LWT_SEL_RST = 3'h0;
    localparam logic [LWT_CNT_W-1:0] LWT_CNT_RST = 7'h00;
    localparam logic [LWT_CNT_W-1:0] LWT_CNT_LAST = 7'h7f;
    localparam logic [LWT_PRE_W-1:0] LWT_PRE_RST = 10'h000;
    localparam logic [LWT_PRE_W-1:0] LWT_DIV_2E4 = 10'h00f;
    localparam logic [LWT_PRE_W-1:0] LWT_DIV_2E6 = 10'h03f;
    localparam logic [LWT_PRE_W-1:0] LWT_DIV_2E8 = 10'h0ff;
    localparam logic [LWT_PRE_W-1:0] LWT_DIV_2E10 = 10'h3ff;

    typedef enum logic [1:0] {
        LWT_STOPPED,
        LWT_INTERVAL,
        LWT_WD_NMI,
        LWT_WD_RESET
    } lwt_mode_e;

    typedef struct packed {
        logic run;
        logic wden;
        logic act;
    } lwt_ctrl_s;
endpackage : lwt_pkg

// >>> lwt_prescaler.sv
// main clock prescaler, counting only while en is high, with selectable tick
module lwt_prescaler import lwt_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [LWT_PRE_W-1:0] pre;
    logic [LWT_PRE_W-1:0] next_pre;
    logic [LWT_PRE_W-1:0] div_mask;

    // bit 0 of the select code is ignored
    always_comb begin
        unique case (sel[2:1])
            2'h0: div_mask = LWT_DIV_2E4;
            2'h1: div_mask = LWT_DIV_2E6;
            2'h2: div_mask = LWT_DIV_2E8;
            2'h3: div_mask = LWT_DIV_2E10;
        endcase
        next_pre = en ? pre + 10'h001 : pre;
        tick = en && ((pre & div_mask) == div_mask);
    end

    // never cleared by a restart, hence the short first interval
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre <= LWT_PRE_RST;
        end else begin
            pre <= next_pre;
        end
    end
endmodule : lwt_prescaler

// >>> lwt_counter.sv
// 7-bit overflow counter driven by prescaler ticks
module lwt_counter import lwt_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic tick,
    output logic [LWT_CNT_W-1:0] cnt,
    output logic ovf
);
    logic [LWT_CNT_W-1:0] next_cnt;
    logic next_ovf;

    always_comb begin
        next_cnt = cnt;
        next_ovf = 1'b0;
        if (clr) begin
            next_cnt = LWT_CNT_RST;
        end else if (tick) begin
            next_cnt = cnt + 7'h01;
            next_ovf = (cnt == LWT_CNT_LAST);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= LWT_CNT_RST;
            ovf <= 1'b0;
        end else begin
            cnt <= next_cnt;
            ovf <= next_ovf;
        end
    end
endmodule : lwt_counter

// >>> lwt_watchdog_tb.sv
// self-checking bench for the loop watchdog / interval timer
module lwt_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lwt_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode_wr = 1'b0;
    logic [7:0] mode_wdata = 8'h00;
    logic cs_wr = 1'b0;
    logic [7:0] cs_wdata = 8'h00;
    logic cpu_stop = 1'b0;
    logic cpu_on_subclock = 1'b0;
    logic interval_irq_mask = 1'b0;
    logic irq_flag_clr = 1'b0;
    logic [7:0] wd_mode_register;
    logic [7:0] wd_clock_select_register;
    logic wd_irq_request_flag;
    logic interval_overflow_irq;
    logic nmi_req;
    logic wdt_reset_req;
    int mismatches = 0;
    int checks_done = 0;
    int n;
    int p;
    logic ev;

    always #25 clk = ~clk;

    lwt_watchdog u_lwt_watchdog (
        .clk(clk), .rst_n(rst_n), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
        .cs_wr(cs_wr), .cs_wdata(cs_wdata), .cpu_stop(cpu_stop),
        .cpu_on_subclock(cpu_on_subclock), .interval_irq_mask(interval_irq_mask),
        .irq_flag_clr(irq_flag_clr), .wd_mode_register(wd_mode_register),
        .wd_clock_select_register(wd_clock_select_register),
        .wd_irq_request_flag(wd_irq_request_flag),
        .interval_overflow_irq(interval_overflow_irq), .nmi_req(nmi_req),
        .wdt_reset_req(wdt_reset_req)
    );

    task stop_test;
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    task wr(input logic is_cs, input logic [7:0] d);
        @(posedge clk);
        if (is_cs) begin
            cs_wr <= 1'b1;
            cs_wdata <= d;
        end else begin
            mode_wr <= 1'b1;
            mode_wdata <= d;
        end
        @(posedge clk);
        cs_wr <= 1'b0;
        mode_wr <= 1'b0;
    endtask : wr

    task rd_chk(input logic [7:0] em, input logic [7:0] ec);
        @(posedge clk);
        #1;
        check(wd_mode_register, em);
        check(wd_clock_select_register, ec);
    endtask : rd_chk

    // 0 flag, 1 nmi, 2 reset request
    task wait_sig(input int which, input int lim, output int cnt);
        logic hit;
        hit = 1'b0;
        cnt = 0;
        while (!hit && cnt < lim) begin
            @(posedge clk);
            cnt++;
            #1;
            case (which)
                0: hit = (wd_irq_request_flag === 1'b1);
                1: hit = (nmi_req === 1'b1);
                default: hit = (wdt_reset_req === 1'b1);
            endcase
        end
        if (!hit) begin
            mismatches++;
            stop_test();
        end
    endtask : wait_sig

    task quiet(input int lim, output logic seen);
        seen = 1'b0;
        repeat (lim) begin
            @(posedge clk);
            #1;
            seen = seen | wd_irq_request_flag | nmi_req | wdt_reset_req;
        end
    endtask : quiet

    task pulse_clr;
        @(posedge clk);
        irq_flag_clr <= 1'b1;
        @(posedge clk);
        irq_flag_clr <= 1'b0;
    endtask : pulse_clr

    task in_range(input int v, input int per);
        check({7'h00, (v >= per - (per >> 7) - 2 && v <= per + 3)}, 8'h01);
    endtask : in_range

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(8'h00, 8'h00);
        check({5'h00, wd_irq_request_flag, nmi_req, wdt_reset_req}, 8'h00);
        for (int s = 0; s < 2; s++) begin
            do_reset();
            p = 2048 << (2 * s);
            wr(1'b1, 8'(2 * s));
            wr(1'b0, 8'h88);
            wait_sig(0, p + 8, n);
            in_range(n, p);
            pulse_clr();
            wait_sig(0, p + 8, n);
            check(8'(n + 2 == p), 8'h01);
            @(posedge clk);
            #1;
            check({7'h00, interval_overflow_irq}, 8'h01);
            interval_irq_mask <= 1'b1;
            repeat (2) @(posedge clk);
            #1;
            check({7'h00, interval_overflow_irq}, 8'h00);
            interval_irq_mask <= 1'b0;
        end
        wr(1'b1, 8'hfc);
        rd_chk(8'h88, 8'h04);
        wr(1'b1, 8'hfe);
        wr(1'b0, 8'h00);
        rd_chk(8'h88, 8'h06);
        wr(1'b1, 8'h00);
        wr(1'b0, 8'h88);
        pulse_clr();
        cpu_stop <= 1'b1;
        quiet(3000, ev);
        check({7'h00, ev}, 8'h00);
        cpu_stop <= 1'b0;
        cpu_on_subclock <= 1'b1;
        quiet(3000, ev);
        check({7'h00, ev}, 8'h00);
        cpu_on_subclock <= 1'b0;
        wait_sig(0, 2100, n);
        check({7'h00, n > 8}, 8'h01);
        do_reset();
        wr(1'b0, 8'h98);
        wr(1'b0, 8'h00);
        wr(1'b0, 8'h88);
        rd_chk(8'h98, 8'h00);
        repeat (3) begin
            wr(1'b0, 8'h98);
            quiet(1500, ev);
            check({7'h00, ev}, 8'h00);
        end
        wr(1'b0, 8'h98);
        wait_sig(2, 2100, n);
        in_range(n, 2048);
        check({7'h00, nmi_req}, 8'h00);
        @(posedge clk);
        #1;
        check({7'h00, wdt_reset_req}, 8'h00);
        do_reset();
        wr(1'b0, 8'h88);
        wait_sig(0, 2100, n);
        wr(1'b0, 8'h90);
        #1;
        check({7'h00, nmi_req}, 8'h01);
        do_reset();
        wr(1'b0, 8'h90);
        rd_chk(8'h90, 8'h00);
        wait_sig(1, 2100, n);
        in_range(n + 2, 2048);
        check({7'h00, wdt_reset_req}, 8'h00);
        stop_test();
    end
endmodule : lwt_watchdog_tb
